/* logic/csie_top.sv */
// clock-select and interrupt-enable control, AXI4-Lite slave
// assumes flags, write-once and mode come from logic on aclk;
// osc qualification and aux clock arrive asynchronous
//
// Functional notes
// (R01) tick enable bit 7 passes the tick flag as interrupt request
// (R02) lock enable bit 4 passes the lock-change flag as request
// (R03) osc enable bit 1 passes the osc-change flag as request
// (R04) protect set: every clock-select write is ignored, any mode
// (R05) special mode, unprotected: all clock-select bits writable
// (R06) normal mode: pll, pseudo stop, tick/wd pseudo, tick clock always
// (R07) normal mode: watchdog stop gate and selects only before write-once
// (R08) osc select cleared by lost qualification may be set once again
// (R09) aux select survives lost qualification, settable only in special mode or before write-once
// (R10) software reads back clock-select to confirm selections
// (R11) pll select picks pll or oscillator as system source, bus half
// (R12) pll select clears only while oscillator qualified
// (R13) lost qualification or full stop entry forces pll select
// (R14) pseudo stop keeps oscillator running in stop, else off
// (R15) software waits oscillator start-up before pseudo stop
// (R16) stop-clock disable gates watchdog aux clock in stop, wakeup clock untouched
// (R17) aux-clock stop gating synchronised through two stages stepped by aux edges
// (R18) software waits two aux cycles before next stop request
// (R19) aux select picks aux clock, change restarts watchdog
// (R20) while aux selected, osc select neither steers nor restarts
// (R21) tick runs in pseudo stop only with enable and osc clock
// (R22) watchdog runs in pseudo stop only with enable and osc clock
// (R23) tick clock select sets only if qualified, cleared on loss
// (R24) qualified status mirrors oscillator, cleared in full stop
`timescale 1ns/100ps
`include "csie_regs.svh"
module csie_top import csie_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // neighbouring blocks
  input wire logic special_mode,
  input wire logic register_protect,
  input wire logic watchdog_ctrl_written,
  input wire logic stop_mode,
  input wire logic tick_flag,
  input wire logic lock_change_flag,
  input wire logic osc_change_flag,
  // asynchronous inputs
  input wire logic osc_qualified_async,
  input wire logic aux_clock_async,
  // interrupt requests
  output csie_irq_t irq_req,
  // clock steering
  output logic sysclk_from_pll,
  output logic oscillator_enable,
  output logic tick_run,
  output logic tick_restart,
  output csie_wd_src_t watchdog_src,
  output logic watchdog_run,
  output logic watchdog_restart,
  output logic watchdog_aux_enable,
  output logic osc_qualified
);

  localparam logic [ADDR_W-1:0] A_INT = ADDR_W'(`CSIE_IDX_INTENA * 4);
  localparam logic [ADDR_W-1:0] A_CLK = ADDR_W'(`CSIE_IDX_CLKSEL * 4);
  localparam logic [ADDR_W-1:0] A_STA = ADDR_W'(`CSIE_IDX_STATUS * 4);

  function automatic csie_wd_src_t wd_src(input csie_clksel_t c);
    if (c.watchdog_aux_clock_select)
      return CSIE_WD_AUX;
    else if (c.watchdog_osc_select)
      return CSIE_WD_OSC;
    return CSIE_WD_IRC;
  endfunction

  // synchronisers: first stage read only by the second
  logic oq_s1_q, oq_s2_q, ax_s1_q, ax_s2_q, ax_s3_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oq_s1_q <= 1'b0;
      oq_s2_q <= 1'b0;
      ax_s1_q <= 1'b0;
      ax_s2_q <= 1'b0;
      ax_s3_q <= 1'b0;
    end else if (ce) begin
      oq_s1_q <= osc_qualified_async;
      oq_s2_q <= oq_s1_q;
      ax_s1_q <= aux_clock_async;
      ax_s2_q <= ax_s1_q;
      ax_s3_q <= ax_s2_q;
    end
  end

  logic aux_edge;
  assign aux_edge = ax_s2_q & ~ax_s3_q;

  // axi write channel
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic wr_go;
  assign wr_go = aw_have_q & w_have_q & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `CSIE_RESP_OKAY;
    end else if (ce) begin
      awready <= ~aw_have_q & ~(awvalid & awready);
      wready <= ~w_have_q & ~(wvalid & wready);
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bresp <= (aw_addr_q == A_INT || aw_addr_q == A_CLK ||
                  aw_addr_q == A_STA) ? `CSIE_RESP_OKAY : `CSIE_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  logic wr_int, wr_clk;
  assign wr_int = wr_go & w_lane_q & (aw_addr_q == A_INT);
  assign wr_clk = wr_go & w_lane_q & (aw_addr_q == A_CLK);

  // write-once of the watchdog control, sticky until reset
  logic wo_done_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      wo_done_q <= 1'b0;
    else if (ce && watchdog_ctrl_written)
      wo_done_q <= 1'b1;
  end

  // stop tracking; full stop entered on stop rise without pseudo stop
  csie_clksel_t cs_q, cs_d;
  logic stop_q, full_stop, full_entry;
  assign full_entry = stop_mode & ~stop_q & ~cs_q.pseudo_stop_select;
  assign full_stop = stop_mode & ~cs_q.pseudo_stop_select;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      stop_q <= 1'b0;
    else if (ce)
      stop_q <= stop_mode;
  end

  logic oq;
  assign oq = oq_s2_q & ~full_stop; // R24

  // interrupt enable register
  logic [7:0] ie_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ie_q <= `CSIE_RST_INTENA;
    else if (ce && wr_int)
      ie_q <= w_data_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= '0;
    end else if (ce) begin
      irq_req.tick <= tick_flag & ie_q[`CSIE_BIT_TICK_IE]; // R01
      irq_req.lock_change <= lock_change_flag & ie_q[`CSIE_BIT_LOCK_IE]; // R02
      irq_req.osc_change <= osc_change_flag & ie_q[`CSIE_BIT_OSC_IE]; // R03
    end
  end

  // clock-select register
  logic open_all, open_once, wd_lost_q, osc_rearm;
  csie_clksel_t wv;
  assign wv = csie_clksel_t'(w_data_q);
  assign open_all = wr_clk & ~register_protect; // R04
  assign open_once = open_all & (special_mode | ~wo_done_q); // R05 R07
  assign osc_rearm = open_all & wd_lost_q; // R08

  always_comb begin
    cs_d = cs_q;
    if (open_all) begin // R06
      cs_d.sysclk_from_pll = wv.sysclk_from_pll | ~oq; // R12
      cs_d.pseudo_stop_select = wv.pseudo_stop_select;
      cs_d.tick_in_pseudo_stop = wv.tick_in_pseudo_stop;
      cs_d.watchdog_in_pseudo_stop = wv.watchdog_in_pseudo_stop;
      cs_d.tick_clock_select = wv.tick_clock_select & oq; // R23
    end
    if (open_once) begin // R07
      cs_d.watchdog_stop_clock_disable = wv.watchdog_stop_clock_disable;
      cs_d.watchdog_aux_clock_select = wv.watchdog_aux_clock_select; // R09
    end
    if (open_once || (osc_rearm && wv.watchdog_osc_select))
      cs_d.watchdog_osc_select = wv.watchdog_osc_select & oq;
    if (!oq) begin
      cs_d.tick_clock_select = 1'b0; // R23
      cs_d.watchdog_osc_select = 1'b0;
    end
    if (!oq || full_entry)
      cs_d.sysclk_from_pll = 1'b1; // R13
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      cs_q <= csie_clksel_t'(`CSIE_RST_CLKSEL);
    else if (ce)
      cs_q <= cs_d;
  end

  // loss-cleared marker; the loss wins over a re-arm in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      wd_lost_q <= 1'b0;
    else if (ce) begin
      if (!oq && cs_q.watchdog_osc_select)
        wd_lost_q <= 1'b1;
      else if (cs_q.watchdog_osc_select)
        wd_lost_q <= 1'b0;
    end
  end

  // stop gating of the watchdog aux clock, stepped by aux edges
  logic [`CSIE_AUX_SYNC_STAGES-1:0] ax_stop_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ax_stop_q <= '0;
    else if (ce && aux_edge)
      ax_stop_q <= {ax_stop_q[`CSIE_AUX_SYNC_STAGES-2:0], stop_mode}; // R17
  end

  // steering outputs
  logic osc_wd, wd_src_chg;
  csie_wd_src_t src_now;
  assign src_now = wd_src(cs_q);
  assign osc_wd = (src_now == CSIE_WD_OSC);
  assign wd_src_chg = (wd_src(cs_d) != src_now); // R19 R20

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysclk_from_pll <= 1'b1;
      oscillator_enable <= 1'b1;
      tick_run <= 1'b1;
      tick_restart <= 1'b0;
      watchdog_src <= CSIE_WD_IRC;
      watchdog_run <= 1'b1;
      watchdog_restart <= 1'b0;
      watchdog_aux_enable <= 1'b1;
      osc_qualified <= 1'b0;
    end else if (ce) begin
      // bus clock is this source halved downstream
      sysclk_from_pll <= cs_q.sysclk_from_pll; // R11
      oscillator_enable <= ~stop_mode | cs_q.pseudo_stop_select; // R14
      tick_run <= ~stop_mode | (cs_q.pseudo_stop_select &
                  cs_q.tick_in_pseudo_stop & cs_q.tick_clock_select); // R21
      tick_restart <= cs_d.tick_clock_select != cs_q.tick_clock_select;
      watchdog_src <= src_now; // R19
      watchdog_run <= ~stop_mode | (cs_q.pseudo_stop_select &
                      cs_q.watchdog_in_pseudo_stop & osc_wd); // R22
      watchdog_restart <= wd_src_chg; // R20
      // only the watchdog branch is gated; the wakeup timer keeps its clock
      watchdog_aux_enable <= ~(ax_stop_q[`CSIE_AUX_SYNC_STAGES-1] &
                             cs_q.watchdog_stop_clock_disable); // R16
      osc_qualified <= oq; // R24
    end
  end

  // read channel; status word is read-only
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (araddr == A_INT)
      rd_mux = ie_q & 8'h92;
    else if (araddr == A_CLK)
      rd_mux = cs_q; // R10
    else if (araddr == A_STA)
      rd_mux = {3'h0, wd_lost_q, src_now, stop_q, oq};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `CSIE_RESP_OKAY;
    end else if (ce) begin
      arready <= ~rvalid & ~(arvalid & arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_mux};
        rresp <= (araddr == A_INT || araddr == A_CLK || araddr == A_STA) ?
                 `CSIE_RESP_OKAY : `CSIE_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_tick_irq_on: assert property (ce && tick_flag && ie_q[7] |=> irq_req.tick)
    else $error("tick request missing"); // R01
  a_lock_irq_off: assert property (ce && !ie_q[4] |=> !irq_req.lock_change)
    else $error("lock request while disabled"); // R02
  a_osc_irq_gate: assert property (ce |=> irq_req.osc_change ==
      $past(osc_change_flag & ie_q[1]))
    else $error("osc request wrong"); // R03
  a_protect_hold: assert property (ce && wr_clk && register_protect
      |=> $stable(cs_q.pseudo_stop_select))
    else $error("protected write took effect"); // R04
  a_special_write: assert property (ce && wr_clk && special_mode &&
      !register_protect |=> cs_q.watchdog_stop_clock_disable == $past(w_data_q[5]))
    else $error("special write lost"); // R05
  a_once_lock: assert property (ce && wr_clk && !special_mode && wo_done_q
      |=> $stable(cs_q.watchdog_stop_clock_disable))
    else $error("write-once not honoured"); // R07
  a_pll_forced: assert property (ce && !oq |=> cs_q.sysclk_from_pll ##1
      (!$past(ce) || sysclk_from_pll))
    else $error("pll select not forced"); // R13
  a_tick_clr: assert property (ce && !oq |=> !cs_q.tick_clock_select)
    else $error("tick clock select kept"); // R23
  a_aux_keep: assert property (ce && !wr_clk |=> $stable(cs_q.watchdog_aux_clock_select))
    else $error("aux select changed by hardware"); // R09
  a_full_stop_q: assert property (ce && full_stop |=> !osc_qualified)
    else $error("qualified in full stop"); // R24

  c_irq_tick: cover property (ce && tick_flag && ie_q[7] ##1 irq_req.tick);
  c_pll_clear: cover property (wr_clk && oq && !wv.sysclk_from_pll ##1 !cs_q.sysclk_from_pll);
  c_rearm: cover property (osc_rearm && wv.watchdog_osc_select && oq);
  c_aux_gate: cover property (!watchdog_aux_enable);

endmodule

/* logic/csie_regs.svh */
// register indices, field positions and reset values
// assumes a 32-bit word per register, byte address = index * 4
`ifndef CSIE_REGS_SVH
`define CSIE_REGS_SVH
`define CSIE_IDX_INTENA 12'h038
`define CSIE_IDX_CLKSEL 12'h039
`define CSIE_IDX_STATUS 12'h040
`define CSIE_BIT_TICK_IE 7
`define CSIE_BIT_LOCK_IE 4
`define CSIE_BIT_OSC_IE 1
`define CSIE_BIT_PLL 7
`define CSIE_BIT_PSEUDO_STOP 6
`define CSIE_BIT_WD_STOP_GATE 5
`define CSIE_BIT_WDAUX 4
`define CSIE_BIT_TPS 3
`define CSIE_BIT_WPS 2
`define CSIE_BIT_TICKOSC 1
`define CSIE_BIT_WDOSC 0
`define CSIE_RST_INTENA 8'h00
`define CSIE_RST_CLKSEL 8'h80
`define CSIE_AUX_SYNC_STAGES 2
`define CSIE_RESP_OKAY 2'h0
`define CSIE_RESP_SLVERR 2'h2
`endif

/* logic/csie_pkg.sv */
// types shared by the clock-select and interrupt-enable block
// no dependencies
package csie_pkg;
  typedef struct packed {
    logic sysclk_from_pll;
    logic pseudo_stop_select;
    logic watchdog_stop_clock_disable;
    logic watchdog_aux_clock_select;
    logic tick_in_pseudo_stop;
    logic watchdog_in_pseudo_stop;
    logic tick_clock_select;
    logic watchdog_osc_select;
  } csie_clksel_t;
  typedef struct packed {
    logic tick;
    logic lock_change;
    logic osc_change;
  } csie_irq_t;
  typedef enum logic [1:0] {
    CSIE_WD_IRC,
    CSIE_WD_OSC,
    CSIE_WD_AUX
  } csie_wd_src_t;
endpackage

/* tb/csie_top_tb.sv */
// self-checking bench for the clock-select and interrupt-enable block
// assumes csie_pkg and csie_regs.svh on the compile path; drives all ports itself
`timescale 1ns/100ps
`include "csie_regs.svh"
module csie_top_tb import csie_pkg::*;;
  localparam logic [11:0] A_IE = 12'(`CSIE_IDX_INTENA * 4);
  localparam logic [11:0] A_CS = 12'(`CSIE_IDX_CLKSEL * 4);
  localparam logic [1:0] OK = `CSIE_RESP_OKAY;
  localparam logic [1:0] SE = `CSIE_RESP_SLVERR;
  logic aclk, aresetn, ce;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic special_mode, register_protect, watchdog_ctrl_written, stop_mode;
  logic tick_flag, lock_change_flag, osc_change_flag, osc_qualified_async;
  logic aux_clock_async = 1'b0;
  csie_irq_t irq_req;
  csie_wd_src_t watchdog_src;
  logic sysclk_from_pll, oscillator_enable, tick_run, tick_restart, watchdog_run;
  logic watchdog_restart, watchdog_aux_enable, osc_qualified;
  logic [33:0] exp_b[$];
  logic [33:0] exp_r[$];
  int errors, compares, tick_rs0, wd_rs0;
  int aux_cnt = 0;
  int tick_rs_n = 0;
  int wd_rs_n = 0;
  logic [31:0] rnd;

  csie_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .special_mode(special_mode), .register_protect(register_protect),
    .watchdog_ctrl_written(watchdog_ctrl_written), .stop_mode(stop_mode), .tick_flag(tick_flag),
    .lock_change_flag(lock_change_flag), .osc_change_flag(osc_change_flag),
    .osc_qualified_async(osc_qualified_async), .aux_clock_async(aux_clock_async), .irq_req(irq_req),
    .sysclk_from_pll(sysclk_from_pll), .oscillator_enable(oscillator_enable), .tick_run(tick_run),
    .tick_restart(tick_restart), .watchdog_src(watchdog_src), .watchdog_run(watchdog_run),
    .watchdog_restart(watchdog_restart), .watchdog_aux_enable(watchdog_aux_enable),
    .osc_qualified(osc_qualified));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // aux clock: period of six bus cycles, phase unrelated to reads and writes
  always @(posedge aclk) begin
    aux_cnt <= (aux_cnt == 2) ? 0 : aux_cnt + 1;
    if (aux_cnt == 2) begin
      aux_clock_async <= ~aux_clock_async;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic close_out();
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] expd);
    compares++;
    if (seen !== expd) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic give_up();
    errors++;
    $display("Error at %0t: bus wait ran out", $time);
    close_out();
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw_done, w_done;
    @(posedge aclk);
    exp_b.push_back({er, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (++n > 200) give_up();
    end
    do begin
      @(posedge aclk);
      if (++n > 400) give_up();
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    exp_r.push_back({er, 24'h0, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (++n > 200) give_up();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      if (++n > 400) give_up();
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // restart pulses stand one cycle; count them at the edges where they stand
  always @(posedge aclk) begin
    if (tick_restart === 1'b1) tick_rs_n <= tick_rs_n + 1;
    if (watchdog_restart === 1'b1) wd_rs_n <= wd_rs_n + 1;
  end

  // watcher: every bus answer is paired with the oldest note of its channel
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      if (exp_b.size() == 0) chk(34'h3ffffffff, 34'h0);
      else chk({bresp, 32'h0}, exp_b.pop_front());
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (exp_r.size() == 0) chk(34'h3ffffffff, 34'h0);
      else chk({rresp, rdata}, exp_r.pop_front());
    end
  end

  initial begin
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    {special_mode, register_protect, watchdog_ctrl_written, stop_mode} = '0;
    {tick_flag, lock_change_flag, osc_change_flag, osc_qualified_async} = '0;
    ce = 1'b1;
    errors = 0;
    compares = 0;
    rnd = 32'd47316;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(A_IE, `CSIE_RST_INTENA, OK);
    rd(A_CS, `CSIE_RST_CLKSEL, OK);
    rd(12'h0f0, 8'h00, SE);
    wr(12'h0f4, 8'h5a, SE);
    // random enables against random flags, unused bits must read zero
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      wr(A_IE, rnd[7:0], OK);
      tick_flag <= rnd[8];
      lock_change_flag <= rnd[9];
      osc_change_flag <= rnd[10];
      repeat (3) @(posedge aclk);
      chk({31'h0, irq_req}, {31'h0, rnd[8] & rnd[7], rnd[9] & rnd[4], rnd[10] & rnd[1]});
      rd(A_IE, rnd[7:0] & 8'h92, OK);
    end
    // oscillator not qualified: pll cannot clear, tick osc cannot set
    wr(A_CS, 8'h7f, OK);
    rd(A_CS, 8'hfc, OK);
    chk({33'h0, sysclk_from_pll}, 34'h1);
    osc_qualified_async <= 1'b1;
    repeat (6) @(posedge aclk);
    tick_rs0 = tick_rs_n;
    wd_rs0 = wd_rs_n;
    wr(A_CS, 8'h13, OK);
    rd(A_CS, 8'h13, OK);
    // tick select changed; osc select changed under aux: no watchdog restart
    chk({2'h0, 16'(tick_rs_n - tick_rs0), 16'(wd_rs_n - wd_rs0)}, {2'h0, 16'h1, 16'h0});
    chk({33'h0, sysclk_from_pll}, 34'h0);
    chk({33'h0, osc_qualified}, 34'h1);
    // loss of qualification: pll forced, osc selects cleared, aux select kept
    tick_rs0 = tick_rs_n;
    wd_rs0 = wd_rs_n;
    osc_qualified_async <= 1'b0;
    repeat (8) @(posedge aclk);
    chk({33'h0, sysclk_from_pll}, 34'h1);
    rd(A_CS, 8'h90, OK);
    chk({2'h0, 16'(tick_rs_n - tick_rs0), 16'(wd_rs_n - wd_rs0)}, {2'h0, 16'h1, 16'h0});
    osc_qualified_async <= 1'b1;
    watchdog_ctrl_written <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(A_CS, 8'h03, OK);
    rd(A_CS, 8'h13, OK);
    wr(A_CS, 8'h00, OK);
    rd(A_CS, 8'h11, OK);
    register_protect <= 1'b1;
    wr(A_CS, 8'hff, OK);
    rd(A_CS, 8'h11, OK);
    register_protect <= 1'b0;
    special_mode <= 1'b1;
    tick_rs0 = tick_rs_n;
    wd_rs0 = wd_rs_n;
    wr(A_CS, 8'h2c, OK);
    rd(A_CS, 8'h2c, OK);
    // aux select dropped: watchdog source moves, one restart
    chk({2'h0, 16'(tick_rs_n - tick_rs0), 16'(wd_rs_n - wd_rs0)}, {2'h0, 16'h0, 16'h1});
    // full stop with aux gating requested; gated after two aux edges, four aux cycles waited
    stop_mode <= 1'b1;
    repeat (24) @(posedge aclk);
    chk({33'h0, sysclk_from_pll}, 34'h1);
    chk({33'h0, oscillator_enable}, 34'h0);
    chk({33'h0, osc_qualified}, 34'h0);
    chk({33'h0, watchdog_aux_enable}, 34'h0);
    chk({32'h0, tick_run, watchdog_run}, 34'h0);
    rd(A_CS, 8'hac, OK);
    stop_mode <= 1'b0;
    repeat (30) @(posedge aclk);
    chk({32'h0, watchdog_aux_enable, osc_qualified}, 34'h3);
    // pseudo stop with tick and watchdog on the oscillator
    wr(A_CS, 8'h4f, OK);
    rd(A_CS, 8'h4f, OK);
    stop_mode <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({32'h0, oscillator_enable, sysclk_from_pll}, 34'h2);
    chk({32'h0, tick_run, watchdog_run}, 34'h3);
    chk({32'h0, watchdog_src}, {32'h0, CSIE_WD_OSC});
    stop_mode <= 1'b0;
    wr(A_CS, 8'h5f, OK);
    repeat (3) @(posedge aclk);
    chk({32'h0, watchdog_src}, {32'h0, CSIE_WD_AUX});
    // clock enable low freezes state: the loss is seen only once it returns
    ce <= 1'b0;
    osc_qualified_async <= 1'b0;
    repeat (8) @(posedge aclk);
    chk({32'h0, sysclk_from_pll, osc_qualified}, 34'h1);
    ce <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({32'h0, sysclk_from_pll, osc_qualified}, 34'h2);
    // reset in mid-run returns both registers and the steering to reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({32'h0, watchdog_src}, {32'h0, CSIE_WD_IRC});
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(A_CS, `CSIE_RST_CLKSEL, OK);
    rd(A_IE, `CSIE_RST_INTENA, OK);
    repeat (5) @(posedge aclk);
    if (exp_b.size() != 0 || exp_r.size() != 0) chk(34'h3ffffffff, 34'h0);
    close_out();
  end
endmodule
